// [logic/cpc_calibration_ctrl.sv]
/*
 * Calibration control: trigger selection, low-power background
 * recalibration timing and the byte-wide calibration vector port.
 * Assumes a single-cycle register port with read data one cycle later,
 * an external calibration engine on the same clock, and a trigger pin
 * that is asynchronous to the clock.
 */
// What this block does
// - Software trigger bit, reset one, behaves as the trigger pin when select is zero.
// - Nap code in bits 7-5 gives (2^N+1)*256 clocks, N from 3..33.
// - Nap timing only applies with low-power on and trigger napping off.
// - Settle code in bits 4-3 gives (2^N+1)*256 clocks before recalibrating.
// - Nap-until-trigger zero uses the timer; one wakes on a low trigger.
// - Low-power enable bit 0 works only while background calibration is on.
// - Port enable bit 0 opens the calibration data register.
// - Each port read returns the next byte; 673 reads give the vector.
// - 673 port writes load saved bytes into successive vector positions.
// - Streaming with a held address works since the port self-advances.
// - A sequence stopped before 673 accesses leaves the data invalid.
// - Select zero uses the software bit; one uses the trigger pin.
// - Halted status shows one when calibration stopped, zero when running.
// - Background calibration enable, reset zero, turns background calibration on.
`default_nettype none

module cpc_calibration_ctrl
    import cpc_pkg::*;
#(
    // Nap exponents for codes 7 down to 0.
    parameter logic [7:0][5:0] NAP_EXP = {
        6'd33, 6'd30, 6'd27, 6'd24,
        6'd21, 6'd18, 6'd15, 6'd3
    },
    // Settle exponents for codes 3 down to 0.
    parameter logic [3:0][5:0] SETTLE_EXP = {6'd24, 6'd21, 6'd18, 6'd3},
    // Clock periods per delay unit.
    parameter logic [15:0] UNIT = 16'(DLY_UNIT_PERIODS)
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    // Register port.
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Trigger pin.
    input wire logic calibration_trigger_pin,
    // Calibration engine.
    input wire logic cal_halted_in,
    input wire logic recal_done_in,
    output logic calibration_trigger,
    output logic background_recal_enable,
    output logic economy_active,
    output logic recal_req,
    output logic core_asleep,
    output logic core_settling,
    // Vector access for the engine.
    input wire logic eng_vec_we,
    input wire logic [IDX_W-1:0] eng_vec_idx,
    input wire logic [7:0] eng_vec_wdata,
    output logic [7:0] eng_vec_rdata,
    output logic vector_valid
);

    // ------------
    // Configuration registers.
    // ------------
    logic [7:0] cal_cfg_ff;
    logic [7:0] pin_cfg_ff;
    logic [7:0] soft_trig_ff;
    logic [7:0] econ_cfg_ff;
    logic [7:0] port_en_ff;

    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic port_rd_ff;

    logic trig_meta_ff;
    logic trig_sync_ff;

    logic wr_cal_cfg;
    logic wr_pin_cfg;
    logic wr_soft_trig;
    logic wr_econ_cfg;
    logic wr_port_en;
    logic sel_port;
    logic port_rd_strobe;
    logic port_wr_strobe;

    logic trigger_source_select;
    logic software_recal_kick;
    logic nap_until_trigger;
    logic economy_recal_enable;
    logic port_enabled;
    logic [2:0] idle_nap_interval;
    logic [1:0] post_wake_settle_interval;
    logic [CNT_W-1:0] nap_cycles;
    logic [CNT_W-1:0] settle_cycles;
    logic [7:0] status_byte;
    logic [7:0] store_rdata;
    logic seq_valid;

    // ------------
    // Address decode.
    // ------------
    // Offset match, shared by every strobe decode below.
    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        return addr == ofs;
    endfunction

    // Writes to unmapped offsets are dropped; status is read-only.
    assign wr_cal_cfg = reg_wr && hit(reg_addr, OFS_CAL_CFG);
    assign wr_pin_cfg = reg_wr && hit(reg_addr, OFS_PIN_CFG);
    assign wr_soft_trig = reg_wr && hit(reg_addr, OFS_SOFT_TRIG);
    assign wr_econ_cfg = reg_wr && hit(reg_addr, OFS_ECON_CFG);
    assign wr_port_en = reg_wr && hit(reg_addr, OFS_PORT_EN);
    assign sel_port = hit(reg_addr, OFS_PORT);

    // Strobes aimed at the vector port; the store gates them itself.
    assign port_rd_strobe = reg_rd && sel_port;
    assign port_wr_strobe = reg_wr && sel_port;

    // ------------
    // Field extraction.
    // ------------
    assign background_recal_enable = cal_cfg_ff[BG_EN_BIT];
    assign trigger_source_select = pin_cfg_ff[TSS_BIT];
    assign software_recal_kick = soft_trig_ff[KICK_BIT];
    assign idle_nap_interval = econ_cfg_ff[NAP_MSB:NAP_LSB];
    assign post_wake_settle_interval = econ_cfg_ff[SETTLE_MSB:SETTLE_LSB];
    assign nap_until_trigger = econ_cfg_ff[NAP_TRIG_BIT];
    assign economy_recal_enable = econ_cfg_ff[ECON_EN_BIT];
    assign port_enabled = port_en_ff[PORT_EN_BIT];

    // ------------
    // Register storage.
    // ------------
    // Reserved bits are read/write, so whole bytes are kept as written.
    // Calibration configuration byte.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cal_cfg_ff <= RST_CAL_CFG;
        end else if (wr_cal_cfg) begin
            cal_cfg_ff <= reg_wdata;
        end
    end

    // Trigger source select byte.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_cfg_ff <= RST_PIN_CFG;
        end else if (wr_pin_cfg) begin
            pin_cfg_ff <= reg_wdata;
        end
    end

    // Software trigger; it resets high so an idle part sees no trigger.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            soft_trig_ff <= RST_SOFT_TRIG;
        end else if (wr_soft_trig) begin
            soft_trig_ff <= reg_wdata;
        end
    end

    // Low-power configuration byte.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            econ_cfg_ff <= RST_ECON_CFG;
        end else if (wr_econ_cfg) begin
            econ_cfg_ff <= reg_wdata;
        end
    end

    // Vector port enable byte.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            port_en_ff <= RST_PORT_EN;
        end else if (wr_port_en) begin
            port_en_ff <= reg_wdata;
        end
    end

    // ------------
    // Trigger selection.
    // ------------
    // The pin is asynchronous; two flops before anything looks at it.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            trig_meta_ff <= 1'b1;
            trig_sync_ff <= 1'b1;
        end else begin
            trig_meta_ff <= calibration_trigger_pin;
            trig_sync_ff <= trig_meta_ff;
        end
    end

    // The software bit stands in for the pin, so the engine cannot tell
    // which source drove it.
    assign calibration_trigger = trigger_source_select ?
        trig_sync_ff : software_recal_kick;

    // ------------
    // Low-power recalibration.
    // ------------
    // The low-power enable is inert without background calibration.
    assign economy_active = economy_recal_enable &&
        background_recal_enable;

    // Delay lookup; exponents are parameters so simulation can shrink them.
    assign nap_cycles = cpc_delay_cycles(NAP_EXP[idle_nap_interval],
        UNIT);
    assign settle_cycles = cpc_delay_cycles(
        SETTLE_EXP[post_wake_settle_interval], UNIT);

    cpc_lp_sequencer u_lp_sequencer (
        .clock(clock),
        .rst_b(rst_b),
        .active(economy_active),
        .nap_until_trigger(nap_until_trigger),
        .trigger_level(calibration_trigger),
        .nap_cycles(nap_cycles),
        .settle_cycles(settle_cycles),
        .recal_done(recal_done_in),
        .recal_req(recal_req),
        .core_asleep(core_asleep),
        .core_settling(core_settling)
    );

    // ------------
    // Calibration vector port.
    // ------------
    // The index lives in the store, so a host holding the address and
    // streaming strobes walks the vector with no further addressing.
    cpc_vector_store #(
        .LEN(VEC_LEN)
    ) u_vector_store (
        .clock(clock),
        .rst_b(rst_b),
        .port_en(port_enabled),
        .host_rd(port_rd_strobe),
        .host_wr(port_wr_strobe),
        .host_wdata(reg_wdata),
        .host_rdata(store_rdata),
        .seq_valid(seq_valid),
        .eng_we(eng_vec_we),
        .eng_idx(eng_vec_idx),
        .eng_wdata(eng_vec_wdata),
        .eng_rdata(eng_vec_rdata)
    );

    assign vector_valid = seq_valid;

    // ------------
    // Read path.
    // ------------
    // Halted status mirrors the engine; validity shares the byte.
    assign status_byte = 8'(({7'h00, cal_halted_in} << HALT_BIT) |
        ({7'h00, seq_valid} << VALID_BIT));

    // Read mux; unmapped offsets read as zero.
    always_comb begin
        case (reg_addr)
            OFS_CAL_CFG: nxt_rdata = cal_cfg_ff;
            OFS_CAL_STATUS: nxt_rdata = status_byte;
            OFS_PIN_CFG: nxt_rdata = pin_cfg_ff;
            OFS_SOFT_TRIG: nxt_rdata = soft_trig_ff;
            OFS_ECON_CFG: nxt_rdata = econ_cfg_ff;
            OFS_PORT_EN: nxt_rdata = port_en_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Read data register; it drops back to zero after its one cycle.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
        end
    end

    // An open port read takes the store's own flop in the next cycle.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            port_rd_ff <= 1'b0;
        end else begin
            port_rd_ff <= port_rd_strobe && port_enabled;
        end
    end

    // A closed port reads zero and does not advance.
    assign reg_rdata = port_rd_ff ? store_rdata : rdata_ff;

endmodule

`default_nettype wire

// [logic/cpc_pkg.sv]
/*
 * Shared constants for the calibration trigger, low-power recalibration and
 * calibration vector port block: register offsets, field positions, reset
 * values, the vector length and the delay formula.
 * Assumes an 8-bit register port and one clock for the whole block.
 */
`default_nettype none

package cpc_pkg;

    // ------------
    // Register port geometry and offsets.
    // ------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] OFS_CAL_CFG = 8'h62;
    localparam logic [7:0] OFS_CAL_STATUS = 8'h6a;
    localparam logic [7:0] OFS_PIN_CFG = 8'h6b;
    localparam logic [7:0] OFS_SOFT_TRIG = 8'h6c;
    localparam logic [7:0] OFS_ECON_CFG = 8'h6e;
    localparam logic [7:0] OFS_PORT_EN = 8'h70;
    localparam logic [7:0] OFS_PORT = 8'h71;

    // ------------
    // Reset values.
    // ------------
    localparam logic [7:0] RST_CAL_CFG = 8'h01;
    localparam logic [7:0] RST_PIN_CFG = 8'h00;
    localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
    localparam logic [7:0] RST_ECON_CFG = 8'h88;
    localparam logic [7:0] RST_PORT_EN = 8'h00;

    // ------------
    // Field positions.
    // ------------
    localparam int unsigned BG_EN_BIT = 1;
    localparam int unsigned TSS_BIT = 0;
    localparam int unsigned KICK_BIT = 0;
    localparam int unsigned NAP_MSB = 7;
    localparam int unsigned NAP_LSB = 5;
    localparam int unsigned SETTLE_MSB = 4;
    localparam int unsigned SETTLE_LSB = 3;
    localparam int unsigned NAP_TRIG_BIT = 1;
    localparam int unsigned ECON_EN_BIT = 0;
    localparam int unsigned PORT_EN_BIT = 0;
    localparam int unsigned HALT_BIT = 1;
    localparam int unsigned VALID_BIT = 2;

    // ------------
    // Vector length and delay timing, in sample clock periods.
    // ------------
    localparam int unsigned VEC_LEN = 673;
    localparam int unsigned IDX_W = 10;
    localparam int unsigned DLY_UNIT_PERIODS = 256;
    localparam int unsigned CNT_W = 48;

    // Low-power sequencer states.
    typedef enum logic [1:0] {
        LP_OFF,
        LP_CALIB,
        LP_NAP,
        LP_SETTLE
    } cpc_lp_state_e;

    // Delay in cycles: (2^n + 1) times the unit.
    function automatic logic [CNT_W-1:0] cpc_delay_cycles(
        input logic [5:0] n,
        input logic [15:0] unit
    );
        logic [CNT_W-1:0] pow;
        pow = (48'd1 << n) + 48'd1;
        return CNT_W'(pow * {32'h0, unit});
    endfunction

endpackage

`default_nettype wire

// [logic/cpc_lp_sequencer.sv]
/*
 * Low-power background recalibration sequencer: calibrate, nap, settle,
 * calibrate again.
 * Assumes the calibration engine answers each request with a done pulse.
 */
`default_nettype none

module cpc_lp_sequencer
    import cpc_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    // Mode and timing.
    input wire logic active,
    input wire logic nap_until_trigger,
    input wire logic trigger_level,
    input wire logic [CNT_W-1:0] nap_cycles,
    input wire logic [CNT_W-1:0] settle_cycles,
    // Calibration engine.
    input wire logic recal_done,
    output logic recal_req,
    output logic core_asleep,
    output logic core_settling
);

    cpc_lp_state_e state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic cnt_zero;
    logic nap_over;

    // ------------
    // Transitions.
    // ------------
    assign cnt_zero = (cnt_ff == '0);
    // A timed nap ends on the count, a trigger nap on a low trigger.
    assign nap_over = nap_until_trigger ? !trigger_level : cnt_zero;

    // Next state; losing the mode drops straight back to idle.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = (cnt_ff == '0) ? cnt_ff : cnt_ff - 1'b1;
        case (state_ff)
            LP_OFF: begin
                if (active) begin
                    nxt_state = LP_CALIB;
                end
            end
            LP_CALIB: begin
                if (recal_done) begin
                    nxt_state = LP_NAP;
                    nxt_cnt = nap_cycles - 1'b1;
                end
            end
            LP_NAP: begin
                if (nap_over) begin
                    nxt_state = LP_SETTLE;
                    nxt_cnt = settle_cycles - 1'b1;
                end
            end
            LP_SETTLE: begin
                if (cnt_zero) begin
                    nxt_state = LP_CALIB;
                end
            end
            default: begin
                nxt_state = LP_OFF;
            end
        endcase
        if (!active) begin
            nxt_state = LP_OFF;
        end
    end

    // State registers.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_ff <= LP_OFF;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    assign recal_req = (state_ff == LP_CALIB);
    assign core_asleep = (state_ff == LP_NAP);
    assign core_settling = (state_ff == LP_SETTLE);

endmodule

`default_nettype wire

// [logic/cpc_vector_store.sv]
/*
 * Calibration vector store with a sequential host port and a random
 * access port for the calibration engine.
 * Assumes the host keeps away while calibration runs.
 */
`default_nettype none

module cpc_vector_store
    import cpc_pkg::*;
#(
    parameter int unsigned LEN = VEC_LEN
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    // Host side.
    input wire logic port_en,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic seq_valid,
    // Engine side.
    input wire logic eng_we,
    input wire logic [IDX_W-1:0] eng_idx,
    input wire logic [7:0] eng_wdata,
    output logic [7:0] eng_rdata
);

    logic [7:0] mem [0:LEN-1];
    logic [IDX_W-1:0] idx_ff, nxt_idx;
    logic [7:0] host_rdata_ff, eng_rdata_ff;
    logic valid_ff, nxt_valid;
    logic acc, last;

    // ------------
    // Index and validity.
    // ------------
    assign acc = port_en && (host_rd || host_wr);
    assign last = (idx_ff == IDX_W'(LEN - 1));
    assign nxt_idx = !port_en ? '0 :
        (acc ? (last ? '0 : idx_ff + 1'b1) : idx_ff);
    // Opening a sequence clears validity; only the final byte or reset sets it.
    assign nxt_valid = (acc && last) ? 1'b1 :
        ((acc && idx_ff == '0) ? 1'b0 : valid_ff);

    // Registers.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            idx_ff <= '0;
            valid_ff <= 1'b1;
            host_rdata_ff <= '0;
            eng_rdata_ff <= '0;
        end else begin
            idx_ff <= nxt_idx;
            valid_ff <= nxt_valid;
            if (port_en && host_rd) begin
                host_rdata_ff <= mem[idx_ff];
            end
            eng_rdata_ff <= mem[eng_idx];
        end
    end

    // Storage; the host wins a collision since the engine should be halted.
    always_ff @(posedge clock) begin
        if (port_en && host_wr) begin
            mem[idx_ff] <= host_wdata;
        end else if (eng_we) begin
            mem[eng_idx] <= eng_wdata;
        end
    end

    assign host_rdata = host_rdata_ff;
    assign eng_rdata = eng_rdata_ff;
    assign seq_valid = valid_ff;

endmodule

`default_nettype wire

// [verification/cpc_calibration_ctrl_assertions.sv]
/*
 * Port checker for the calibration control block, bound to its top.
 * Assumes every settle code has the same exponent, as in the bench.
 */
`default_nettype none

module cpc_calibration_ctrl_assertions
    import cpc_pkg::*;
#(
    parameter logic [3:0][5:0] SETTLE_EXP = {4{6'd3}},
    parameter logic [15:0] UNIT = 16'd256
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    // Register port.
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Trigger, sequencer and vector status.
    input wire logic calibration_trigger_pin,
    input wire logic recal_done_in,
    input wire logic calibration_trigger,
    input wire logic background_recal_enable,
    input wire logic economy_active,
    input wire logic recal_req,
    input wire logic core_asleep,
    input wire logic core_settling,
    input wire logic vector_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SLEN = ((1 << SETTLE_EXP[0]) + 1) * UNIT;

    // ------------
    // Shadow state
    // ------------
    // Shadows rebuilt from the strobes, so no internal signal is needed.
    logic pe_ff, tss_ff, kick_ff, bg_ff, lp_ff;
    logic [IDX_W-1:0] idx_ff;
    logic [15:0] sc_ff;
    wire logic wr_pe = reg_wr && reg_addr == OFS_PORT_EN;
    wire logic acc = (reg_wr || reg_rd) && reg_addr == OFS_PORT && pe_ff;
    wire logic last = idx_ff == IDX_W'(VEC_LEN - 1);

    // The settle counter restarts when low power drops, which ends early.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            {pe_ff, tss_ff, kick_ff, bg_ff, lp_ff} <= 5'b00100;
            idx_ff <= '0;
            sc_ff <= '0;
        end else begin
            if (wr_pe) pe_ff <= reg_wdata[0];
            if (reg_wr && reg_addr == OFS_PIN_CFG) tss_ff <= reg_wdata[0];
            if (reg_wr && reg_addr == OFS_SOFT_TRIG) kick_ff <= reg_wdata[0];
            if (reg_wr && reg_addr == OFS_CAL_CFG) bg_ff <= reg_wdata[1];
            if (reg_wr && reg_addr == OFS_ECON_CFG) lp_ff <= reg_wdata[0];
            if (wr_pe && !reg_wdata[0]) idx_ff <= '0;
            else if (acc) idx_ff <= last ? '0 : idx_ff + 1'b1;
            sc_ff <= (core_settling && economy_active) ? sc_ff + 1'b1 : '0;
        end
    end

    // ------------
    // Properties
    // ------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence s_nap_end;
        $fell(core_asleep) && $past(economy_active);
    endsequence
    sequence s_settle_end;
        $fell(core_settling) && sc_ff != 16'h0;
    endsequence

    a_soft_trigger: assert property (
        !tss_ff |-> calibration_trigger == kick_ff)
        else $error("trigger does not follow the software bit");
    a_pin_trigger: assert property (
        tss_ff |-> calibration_trigger == $past(calibration_trigger_pin, 2))
        else $error("trigger does not follow the pin");
    a_bg_enable: assert property (
        background_recal_enable == bg_ff)
        else $error("background enable wrong");
    a_econ_gate: assert property (
        economy_active == (bg_ff && lp_ff))
        else $error("low power active wrong");
    a_calib_start: assert property (
        $rose(economy_active) |=> recal_req)
        else $error("no calibration after low power on");
    a_all_off: assert property (
        !economy_active |=> !(recal_req || core_asleep || core_settling))
        else $error("sequencer busy while low power off");
    a_done_to_nap: assert property (
        economy_active && recal_req && recal_done_in |=> core_asleep)
        else $error("no nap after calibration");
    a_nap_to_settle: assert property (
        s_nap_end |-> core_settling)
        else $error("no settle after nap");
    a_settle_len: assert property (
        s_settle_end |-> sc_ff == SLEN && recal_req)
        else $error("settle length or follow-up wrong");
    a_port_closed: assert property (
        reg_rd && reg_addr == OFS_PORT && !pe_ff |=> reg_rdata == 8'h00)
        else $error("closed port returned data");
    a_valid_clear: assert property (
        acc && !last |=> !vector_valid)
        else $error("partial vector marked valid");
    a_valid_set: assert property (
        acc && last |=> vector_valid)
        else $error("full vector not marked valid");
endmodule

bind cpc_calibration_ctrl cpc_calibration_ctrl_assertions #(
    .SETTLE_EXP(SETTLE_EXP), .UNIT(UNIT)) u_chk (.*);

`default_nettype wire

// [verification/tb_cpc_calibration_ctrl.sv]
/*
 * Self-checking bench for the calibration control block.
 * Assumes the checker is bound in; delays are shortened to ten cycles.
 */
`default_nettype none

module tb_cpc_calibration_ctrl
    import cpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] RA [7] = '{OFS_SOFT_TRIG, OFS_ECON_CFG,
        OFS_PORT_EN, OFS_CAL_CFG, OFS_PIN_CFG, OFS_CAL_STATUS, 8'h55};
    localparam logic [7:0] RV [7] = '{RST_SOFT_TRIG, RST_ECON_CFG,
        RST_PORT_EN, RST_CAL_CFG, RST_PIN_CFG, 8'h06, 8'h00};
    logic clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, erd, d;
    logic pin = 1'b0, halted = 1'b1, done = 1'b0;
    logic [IDX_W-1:0] eidx = '0;
    logic trig, bg_en, econ, req, asleep, settle, valid;
    logic [7:0] vec [VEC_LEN];
    int bad_count = 0, checked = 0, seed = 32'hac27, n;
    wire logic [2:0] st = {settle, asleep, req};

    cpc_calibration_ctrl #(.NAP_EXP({8{6'd2}}), .SETTLE_EXP({4{6'd2}}),
        .UNIT(16'd2)) u_dut (
        .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .calibration_trigger_pin(pin),
        .cal_halted_in(halted), .recal_done_in(done),
        .calibration_trigger(trig), .background_recal_enable(bg_en),
        .economy_active(econ), .recal_req(req), .core_asleep(asleep),
        .core_settling(settle), .eng_vec_we(1'b0), .eng_vec_idx(eidx),
        .eng_vec_wdata(8'h00), .eng_vec_rdata(erd), .vector_valid(valid));

    // A 25 ns clock.
    initial begin
        forever #12.5 clock = ~clock;
    end

    // ------------
    // Helpers
    // ------------
    // Delay in cycles for an exponent, with the bench's unit of two.
    function automatic int dly(input int e);
        return ((1 << e) + 1) * 2;
    endfunction

    task automatic chk(input logic [15:0] s, e, input string nm);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Strobes stay up so accesses can run back to back; idle drops them.
    task automatic acc(input logic w, input logic [7:0] a, dat);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= dat;
        @(posedge clock);
    endtask

    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, dat);
        acc(1'b1, a, dat);
        idle();
    endtask

    task automatic rd(input logic [7:0] a, e);
        acc(1'b0, a, 8'h00);
        idle();
        chk(rdata, e, "read data");
    endtask

    // Bounded waits; wait_st running out counts as a mismatch and ends the run, span just returns.
    task automatic wait_st(input int b);
        for (n = 0; n < 500 && st[b] !== 1'b1; n++) idle();
        if (n == 500) begin
            bad_count++;
            give_verdict();
        end
    endtask

    task automatic span(input int b);
        for (n = 0; n < 500 && st[b] === 1'b1; n++) idle();
    endtask

    task automatic pulse_done();
        done <= 1'b1;
        idle();
        done <= 1'b0;
        idle();
    endtask

    // ------------
    // Main sequence
    // ------------
    initial begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        idle();
        chk(trig, 1'b1, "trigger at reset");
        for (int i = 0; i < 7; i++) rd(RA[i], RV[i]);
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed));
            wr(RA[i], d);
            rd(RA[i], d);
        end
        for (int i = 0; i < 3; i++) wr(RA[i], RV[i]);
        // Software bit drives the trigger with the pin ignored, then the pin drives it once selected.
        wr(OFS_SOFT_TRIG, 8'h00);
        pin <= 1'b1;
        repeat (3) idle();
        chk(trig, 1'b0, "soft trigger low");
        wr(OFS_SOFT_TRIG, 8'h01);
        chk(trig, 1'b1, "soft trigger high");
        wr(OFS_PIN_CFG, 8'h01);
        for (int i = 0; i < 8; i++) begin
            pin <= 1'($random(seed));
            repeat (3) idle();
            chk(trig, pin, "pin trigger");
        end
        wr(OFS_PIN_CFG, 8'h00);
        // Full vector written, then read back as one stream.
        wr(OFS_PORT_EN, 8'h01);
        for (int k = 0; k < VEC_LEN; k++) begin
            vec[k] = 8'($random(seed));
            acc(1'b1, OFS_PORT, vec[k]);
            if (k == 1) chk(valid, 1'b0, "valid mid write");
        end
        idle();
        chk(valid, 1'b1, "valid after write");
        wr(OFS_PORT_EN, 8'h00);
        wr(OFS_PORT_EN, 8'h01);
        for (int k = 0; k <= VEC_LEN; k++) begin
            if (k < VEC_LEN) acc(1'b0, OFS_PORT, 8'h00);
            else idle();
            if (k > 0) chk(rdata, vec[k-1], "vector byte");
        end
        chk(valid, 1'b1, "valid after read");
        eidx <= 10'd672;
        repeat (2) idle();
        chk(erd, vec[672], "engine byte");
        // Partial read, closed port, then the index restarts.
        repeat (5) acc(1'b0, OFS_PORT, 8'h00);
        idle();
        wr(OFS_PORT_EN, 8'h00);
        chk(valid, 1'b0, "valid after partial");
        rd(OFS_PORT, 8'h00);
        wr(OFS_PORT_EN, 8'h01);
        rd(OFS_PORT, vec[0]);
        wr(OFS_PORT_EN, 8'h00);
        halted <= 1'b0;
        rd(OFS_CAL_STATUS, 8'h00);
        halted <= 1'b1;
        // Low power needs background calibration, then timed napping.
        wr(OFS_ECON_CFG, 8'h89);
        chk(econ, 1'b0, "low power without background");
        wr(OFS_CAL_CFG, 8'h03);
        chk(bg_en, 1'b1, "background enable");
        wait_st(0);
        pulse_done();
        span(1);
        chk(16'(n), 16'(dly(2)), "nap length");
        span(2);
        chk(16'(n), 16'(dly(2)), "settle length");
        chk(req, 1'b1, "recalibration");
        // Trigger napping holds past the timer until the trigger is low.
        wr(OFS_ECON_CFG, 8'h8b);
        pulse_done();
        repeat (30) idle();
        chk(asleep, 1'b1, "nap held");
        wr(OFS_SOFT_TRIG, 8'h00);
        span(1);
        chk(n <= 3, 1'b1, "wake on trigger");
        span(2);
        chk(16'(n), 16'(dly(2)), "settle after wake");
        wr(OFS_SOFT_TRIG, 8'h01);
        wr(OFS_CAL_CFG, 8'h01);
        idle();
        chk(st, 3'b000, "sequencer off");
        give_verdict();
    end
endmodule

`default_nettype wire
